// >>> shared/ier_pkg.sv
package ier_pkg;

    // ==========================================================
    // Geometry and timing
    localparam int NCH            = 64;
    localparam int CLK_NS         = 20;
    localparam int TICK_NS        = 1_000_000;
    localparam int TICK_CYC       = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int WDOG_SLACK_CYC = 128;
    localparam int BUF_EV         = 3072;
    localparam int MEM_EV         = 2 * BUF_EV;
    localparam int FALL_HOLD_MULT = 4;

    // ==========================================================
    // Register byte offsets
    localparam logic [15:0] OFF_ID      = 16'h0000;
    localparam logic [15:0] OFF_CSR     = 16'h0004;
    localparam logic [15:0] OFF_STRES   = 16'h0008;
    localparam logic [15:0] OFF_IVEC    = 16'h000C;
    localparam logic [15:0] OFF_EVFLAG  = 16'h0010;
    localparam logic [15:0] OFF_TAG     = 16'h0014;
    localparam logic [15:0] OFF_MAXCNT  = 16'h0018;
    localparam logic [15:0] OFF_EVCNT   = 16'h001C;
    localparam logic [15:0] OFF_INDEX   = 16'h0020;
    localparam logic [15:0] OFF_REQ     = 16'h0024;
    localparam logic [15:0] OFF_DEB     = 16'h0040;
    localparam logic [15:0] OFF_COSF    = 16'h0050;
    localparam logic [15:0] OFF_PACF    = 16'h0060;
    localparam logic [15:0] OFF_CFG     = 16'h0100;
    localparam logic [15:0] OFF_PAC     = 16'h0200;
    localparam logic [15:0] OFF_BUF     = 16'h4000;
    localparam logic [15:0] OFF_BUF_END = 16'hA000;

    // ==========================================================
    // Field positions
    localparam int CSR_LED  = 15;
    localparam int CSR_TEST = 14;
    localparam int CSR_BUSY = 9;
    localparam int CSR_DONE = 8;
    localparam int EVF_TT    = 0;
    localparam int EVF_EOB   = 1;
    localparam int EVF_FIRST = 2;
    localparam int EVF_MAX   = 3;
    localparam int IE_COS   = 0;
    localparam int IE_TT    = 1;
    localparam int IE_PAC   = 2;
    localparam int IE_EOB   = 3;
    localparam int IE_FIRST = 4;
    localparam int IE_MAX   = 5;

    // Accepted address modifiers: A24 and A16, supervisory and user data
    localparam logic [5:0] AM_A24_SUP = 6'h3D;
    localparam logic [5:0] AM_A24_USR = 6'h39;
    localparam logic [5:0] AM_A16_SUP = 6'h2D;
    localparam logic [5:0] AM_A16_USR = 6'h29;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {ST_WRITE, ST_READ, ST_FLUSH, ST_IDLE} ier_stmode_t;

    typedef struct packed {
        logic       pacIe;
        logic       pacFall;
        logic [1:0] cosMode;
        logic       acEn;
        logic [9:0] dbMs;
    } ier_chcfg_t;

    typedef struct packed {
        logic [NCH-1:0]             sync1;
        logic [NCH-1:0]             sync2;
        logic [NCH-1:0]             sample;
        logic [NCH-1:0]             deb;
        logic [NCH-1:0][12:0]       cnt;
        ier_chcfg_t [NCH-1:0]       cfg;
        logic [NCH-1:0][15:0]       pulse_tally;
        logic [NCH-1:0]             cosF;
        logic [NCH-1:0]             pacF;
        logic [15:0]                tickCnt;
        logic [16:0]                wdCnt;
        logic                       scanOn;
        logic [5:0]                 scanIdx;
        logic [15:0]                tag;
        logic [15:0]                maxCnt;
        logic [15:0]                evCnt;
        logic [15:0]                index;
        logic                       fillBuf;
        logic [3:0]                 evF;
        logic                       led;
        logic                       testReq;
        logic [5:0]                 ie;
        logic [2:0]                 irqLvl;
        logic [7:0]                 vec;
        logic                       roakHeld;
        ier_stmode_t                st;
        logic [12:0]                stAddr;
        logic [12:0]                stPrev;
        logic                       stChk;
        logic [1:0]                 stRes;
        logic                       stDone;
        logic                       rdValid;
        logic [7:0]                 vecOut;
        logic                       vecValid;
    } ier_state_t;

endpackage : ier_pkg

// >>> hdl/ier_event_recorder.sv
`timescale 1ns/1ps

// Operation
// - Sample all 64 inputs every 1 ms tick; latest values always readable.
// - Per-channel debounce duration, 1 ms default, up to 1024 ms.
// - AC mode: rise needs duration, fall needs four times duration low.
// - 16-bit pulse tally per channel, counts on one chosen edge only.
// - Pulse tally wrap to zero flags an interrupt when enabled.
// - Change of state flagged on rise, fall, both or never.
// - Time tag advances one count per 1 ms frame.
// - Host may load the time tag anytime; counting resumes from it.
// - Each enabled change appends channel and time tag to active buffer.
// - Buffer-request write swaps the buffers being filled and read.
// - Buffer wraps at its end, count rolls from 3071 to zero.
// - Count tracks filling buffer; request copies it to index, clears it.
// - Interrupts for end of buffer, first word, count equals maximum.
// - Every interrupt source is individually enabled by the host.
// - Request on chosen level, release on acknowledge, byte vector; level 0 disables.
// - Decode A24/A16, supervisory and user modifiers, D16/D8 transfers.
// - Levels, change flags and tally-wrap flags as four 16-bit words.
// - Watchdog resets the engine when a frame kick is missed.
// - Self-test after reset, watchdog or test bit; results recorded.
// - Event is two words: time tag, then level bit 8 and channel.
module ier_event_recorder #(
    parameter int          TICK_CYCLES = ier_pkg::TICK_CYC,
    parameter int          WDOG_CYCLES = ier_pkg::TICK_CYC + ier_pkg::WDOG_SLACK_CYC,
    parameter logic [15:0] BOARD_ID    = 16'h5AA5
)(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [63:0] fieldIn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [5:0]  addrMod,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        iackIn,
    input  wire logic [2:0]  iackLevel,
    output logic             irqReq,
    output logic      [2:0]  irqLevel,
    output logic      [7:0]  vectorOut,
    output logic             vectorValid,
    output logic             ledOn,
    output logic             boardOnline
);
    import ier_pkg::*;

    // BOARD_ID default is arbitrary
    generate
        if (TICK_CYCLES < 128 || TICK_CYCLES > 65536 ||
            WDOG_CYCLES <= TICK_CYCLES + 64 || WDOG_CYCLES > 131071)
        begin : g_badParams
            $error("ier_event_recorder: unsupported timing parameters");
        end
    endgenerate

    ier_state_t  q;
    ier_state_t  d;
    logic [24:0] evMem [MEM_EV];
    logic [24:0] memQ;
    logic        memWe;
    logic [12:0] memWa;
    logic [12:0] memRa;
    logic [24:0] memWd;

    logic        rst;
    logic        amOk;
    logic        isBuf;
    logic        isDeb;
    logic        isCosF;
    logic        isPacF;
    logic        isCfg;
    logic        isPac;
    logic        mapped;
    logic        err;
    logic        wr;
    logic        pend;
    logic [15:0] rd;
    logic [15:0] clr;
    logic [12:0] bufWord;
    logic [5:0]  chSel;
    logic [1:0]  wSel;

    // Self-test pattern ties each word to its own address
    function automatic logic [24:0] stPat(input logic [12:0] a);
        stPat = {a, ~a[11:0]};
    endfunction : stPat

    // D16/D8 writes merge only the enabled byte lanes
    function automatic logic [15:0] wrm(input logic [15:0] o);
        wrm = {pstrb[1] ? pwdata[15:8] : o[15:8], pstrb[0] ? pwdata[7:0] : o[7:0]};
    endfunction : wrm

    // ==========================================================
    // Bus decode
    assign amOk    = addrMod inside {AM_A24_SUP, AM_A24_USR, AM_A16_SUP, AM_A16_USR};
    assign isBuf   = (paddr >= OFF_BUF) && (paddr < OFF_BUF_END);
    assign bufWord = 13'((paddr - OFF_BUF) >> 2);
    assign isDeb   = paddr[15:4] == OFF_DEB[15:4];
    assign isCosF  = paddr[15:4] == OFF_COSF[15:4];
    assign isPacF  = paddr[15:4] == OFF_PACF[15:4];
    assign isCfg   = paddr[15:8] == OFF_CFG[15:8];
    assign isPac   = paddr[15:8] == OFF_PAC[15:8];
    assign chSel   = paddr[7:2];
    assign wSel    = paddr[3:2];
    assign clr     = pwdata[15:0] & {{8{pstrb[1]}}, {8{pstrb[0]}}};
    // Upper byte lanes are refused on writes: only D16 and D8 writes are served
    assign err     = ~amOk | ~mapped | (|paddr[1:0]) | (pwrite & (|pstrb[3:2]));
    assign pready  = ~isBuf | pwrite | q.rdValid;
    assign wr      = psel & penable & pready & pwrite & ~err;
    assign pslverr = psel & penable & err;
    assign prdata  = err ? 32'h0000_0000 : {16'h0000, rd};

    always_comb
    begin
        rd     = 16'h0000;
        mapped = 1'b1;
        if (isBuf)
            rd = paddr[2] ? {7'h00, memQ[8:0]} : memQ[24:9];
        else if (isCfg)
            rd = {1'b0, q.cfg[chSel]};
        else if (isPac)
            rd = q.pulse_tally[chSel];
        else if (isDeb)
            rd = q.deb[wSel*16 +: 16];
        else if (isCosF)
            rd = q.cosF[wSel*16 +: 16];
        else if (isPacF)
            rd = q.pacF[wSel*16 +: 16];
        else
        begin
            case (paddr)
                OFF_ID:     rd = BOARD_ID;
                OFF_CSR:    rd = {q.led, q.testReq, 4'h0, q.st != ST_IDLE, q.stDone, 2'b00, q.ie};
                OFF_STRES:  rd = {14'h0000, q.stRes};
                OFF_IVEC:   rd = {5'h00, q.irqLvl, q.vec};
                OFF_EVFLAG: rd = {12'h000, q.evF};
                OFF_TAG:    rd = q.tag;
                OFF_MAXCNT: rd = q.maxCnt;
                OFF_EVCNT:  rd = q.evCnt;
                OFF_INDEX:  rd = q.index;
                OFF_REQ:    rd = 16'h0000;
                default:    mapped = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // Interrupter
    assign pend = (|q.cosF & q.ie[IE_COS]) | (q.evF[EVF_TT] & q.ie[IE_TT])
                | (|q.pacF & q.ie[IE_PAC]) | (q.evF[EVF_EOB] & q.ie[IE_EOB])
                | (q.evF[EVF_FIRST] & q.ie[IE_FIRST]) | (q.evF[EVF_MAX] & q.ie[IE_MAX]);
    assign irqReq      = pend & (q.irqLvl != 3'd0) & ~q.roakHeld;
    assign irqLevel    = q.irqLvl;
    assign vectorOut   = q.vecOut;
    assign vectorValid = q.vecValid;
    assign ledOn       = q.led;
    assign boardOnline = q.stDone;
    // Missed kick takes the engine through the same path as a system reset
    assign rst = srst | (q.wdCnt == 17'(WDOG_CYCLES));

    // ==========================================================
    // Next state
    always_comb
    begin
        logic        tick;
        logic        anyNew;
        logic        raw;
        logic        lvl;
        logic        cosHit;
        logic [5:0]  i;
        logic [12:0] dur;
        logic [12:0] hold;
        logic [12:0] base;
        ier_chcfg_t  cc;

        d        = q;
        tick     = q.tickCnt == 16'(TICK_CYCLES - 1);
        anyNew   = 1'b0;
        i        = q.scanIdx;
        cc       = q.cfg[i];
        raw      = q.sample[i];
        lvl      = q.deb[i];
        cosHit   = raw ? cc.cosMode[0] : cc.cosMode[1];
        dur      = 13'(cc.dbMs) + 13'd1;
        hold     = (cc.acEn && lvl) ? 13'(dur * FALL_HOLD_MULT) : dur;
        base     = q.fillBuf ? 13'(BUF_EV) : 13'd0;
        memWe    = 1'b0;
        memWa    = 13'd0;
        memWd    = 25'h000_0000;
        memRa    = (q.fillBuf ? 13'd0 : 13'(BUF_EV)) + 13'(bufWord[12:1]);

        d.sync1    = fieldIn;
        d.sync2    = q.sync1;
        d.vecValid = 1'b0;
        d.rdValid  = psel & isBuf & (q.st != ST_READ);
        d.tickCnt  = tick ? 16'h0000 : q.tickCnt + 16'h0001;

        // Host clears go first so a same-cycle event still sets its flag
        if (wr && isCosF)
            d.cosF[wSel*16 +: 16] = q.cosF[wSel*16 +: 16] & ~clr;
        if (wr && isPacF)
            d.pacF[wSel*16 +: 16] = q.pacF[wSel*16 +: 16] & ~clr;
        if (wr && paddr == OFF_EVFLAG)
            d.evF = q.evF & ~clr[3:0];

        // Self-test walks both event buffers, write pass then check pass
        unique case (q.st)
            ST_WRITE:
            begin
                memWe    = 1'b1;
                memWa    = q.stAddr;
                memWd    = stPat(q.stAddr);
                d.stAddr = q.stAddr + 13'd1;
                if (q.stAddr == 13'(MEM_EV - 1))
                begin
                    d.stAddr = 13'd0;
                    d.st     = ST_READ;
                end
            end
            ST_READ:
            begin
                memRa    = q.stAddr;
                d.stChk  = 1'b1;
                d.stPrev = q.stAddr;
                d.stAddr = q.stAddr + 13'd1;
                if (q.stAddr == 13'(MEM_EV - 1))
                    d.st = ST_FLUSH;
            end
            ST_FLUSH:
            begin
                d.stChk  = 1'b0;
                d.stDone = 1'b1;
                d.st     = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (q.testReq)
                begin
                    d.testReq = 1'b0;
                    d.stDone  = 1'b0;
                    d.stRes   = 2'b00;
                    d.stAddr  = 13'd0;
                    d.st      = ST_WRITE;
                end
            end
        endcase
        if (q.stChk && memQ != stPat(q.stPrev))
            d.stRes[q.stPrev >= 13'(BUF_EV)] = 1'b1;

        // Frame start: latch inputs and advance the time tag
        if (tick && q.st == ST_IDLE)
        begin
            d.sample  = q.sync2;
            d.scanOn  = 1'b1;
            d.scanIdx = 6'd0;
            d.tag     = q.tag + 16'h0001;
            if (q.tag == 16'hFFFF)
            begin
                d.evF[EVF_TT] = 1'b1;
                anyNew        = 1'b1;
            end
        end

        // One channel per clock; scanning all 64 channels takes 64 cycles
        if (q.scanOn && q.st == ST_IDLE)
        begin
            if (raw == lvl)
                d.cnt[i] = 13'd0;
            else if (q.cnt[i] + 13'd1 >= hold)
            begin
                d.cnt[i] = 13'd0;
                d.deb[i] = raw;
                if (raw != cc.pacFall)
                begin
                    d.pulse_tally[i] = q.pulse_tally[i] + 16'h0001;
                    if (q.pulse_tally[i] == 16'hFFFF && cc.pacIe)
                    begin
                        d.pacF[i] = 1'b1;
                        anyNew    = 1'b1;
                    end
                end
                if (cosHit)
                begin
                    d.cosF[i] = 1'b1;
                    anyNew    = 1'b1;
                    memWe     = 1'b1;
                    memWa     = base + 13'(q.evCnt);
                    memWd     = {q.tag, raw, 2'b00, i};
                    d.evCnt   = q.evCnt + 16'h0001;
                    if (q.evCnt == 16'h0000)
                        d.evF[EVF_FIRST] = 1'b1;
                    if (q.evCnt + 16'h0001 == q.maxCnt)
                        d.evF[EVF_MAX] = 1'b1;
                    if (q.evCnt == 16'(BUF_EV - 1))
                    begin
                        d.evCnt        = 16'h0000;
                        d.evF[EVF_EOB] = 1'b1;
                    end
                end
            end
            else
                d.cnt[i] = q.cnt[i] + 13'd1;
            d.scanIdx = i + 6'd1;
            if (i == 6'd63)
                d.scanOn = 1'b0;
        end

        // Watchdog kick at the end of every frame's channel scan; idle only while self-testing
        if (q.st != ST_IDLE || (q.scanOn && i == 6'd63))
            d.wdCnt = 17'd0;
        else
            d.wdCnt = q.wdCnt + 17'd1;

        // ======================================================
        // Host data writes win over the engine
        if (wr)
        begin
            if (isCfg)
                d.cfg[chSel] = ier_chcfg_t'(15'(wrm({1'b0, q.cfg[chSel]})));
            if (isPac)
                d.pulse_tally[chSel] = wrm(q.pulse_tally[chSel]);
            case (paddr)
                OFF_CSR:
                begin
                    d.led     = pstrb[1] ? pwdata[CSR_LED] : q.led;
                    d.testReq = pstrb[1] ? pwdata[CSR_TEST] : q.testReq;
                    d.ie      = pstrb[0] ? pwdata[5:0] : q.ie;
                end
                OFF_IVEC:
                begin
                    d.irqLvl = pstrb[1] ? pwdata[10:8] : q.irqLvl;
                    d.vec    = pstrb[0] ? pwdata[7:0] : q.vec;
                end
                OFF_TAG:    d.tag    = wrm(q.tag);
                OFF_MAXCNT: d.maxCnt = wrm(q.maxCnt);
                OFF_INDEX:  d.index  = wrm(q.index);
                OFF_REQ:
                begin
                    // Same-cycle event went to the old buffer and is counted in index
                    d.index   = d.evCnt;
                    d.evCnt   = 16'h0000;
                    d.fillBuf = ~q.fillBuf;
                end
                default:
                begin
                end
            endcase
        end

        // Release on acknowledge; a later event re-arms the request
        if (iackIn && irqReq && iackLevel == q.irqLvl)
        begin
            d.roakHeld = 1'b1;
            d.vecValid = 1'b1;
            d.vecOut   = q.vec;
        end
        if (anyNew)
            d.roakHeld = 1'b0;

        if (rst)
        begin
            d     = '0;
            d.led = 1'b1;
            d.st  = ST_WRITE;
        end
    end

    // ==========================================================
    // Registers and event memory
    always_ff @(posedge clk)
    begin
        q <= d;
    end

    always_ff @(posedge clk)
    begin
        if (memWe)
            evMem[memWa] <= memWd;
        memQ <= evMem[memRa];
    end

endmodule : ier_event_recorder

// >>> verification/ier_properties.sv
`timescale 1ns/1ps

// ====================
// Port-level checks
module ier_properties
    import ier_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [3:0]  pstrb,
    input wire logic [5:0]  addrMod,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        iackIn,
    input wire logic [2:0]  iackLevel,
    input wire logic        irqReq,
    input wire logic [2:0]  irqLevel,
    input wire logic        vectorValid,
    input wire logic        ledOn,
    input wire logic        boardOnline
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic acc;
    logic amOk;
    assign acc  = psel && penable;
    assign amOk = addrMod inside {AM_A24_SUP, AM_A24_USR, AM_A16_SUP, AM_A16_USR};

    a_err_in_access: assert property (pslverr |-> acc)
        else $error("slave error outside access phase");
    a_bad_modifier: assert property (acc && !amOk |-> pslverr)
        else $error("foreign modifier accepted");
    a_wide_lanes: assert property (acc && pwrite && (pstrb[3] || pstrb[2]) |-> pslverr)
        else $error("upper byte lanes accepted");
    a_unaligned_addr: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("unaligned address accepted");
    a_err_reads_zero: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    a_upper_half_zero: assert property (acc && pready |-> prdata[31:16] == 16'h0000)
        else $error("read data wider than a word");
    a_level_zero: assert property (irqLevel == 3'h0 |-> !irqReq)
        else $error("request with level zero");
    a_ack_release: assert property (irqReq && iackIn && iackLevel == irqLevel
        |=> vectorValid && !irqReq)
        else $error("acknowledge did not release");
    a_vector_pulse: assert property (vectorValid |=> !vectorValid)
        else $error("vector strobe longer than one cycle");
    a_reset_state: assert property ($fell(srst) |-> ledOn && !boardOnline)
        else $error("wrong state after reset");
endmodule : ier_properties

bind ier_event_recorder ier_properties ier_properties_i (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pstrb(pstrb), .addrMod(addrMod), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .iackIn(iackIn), .iackLevel(iackLevel), .irqReq(irqReq),
    .irqLevel(irqLevel), .vectorValid(vectorValid), .ledOn(ledOn),
    .boardOnline(boardOnline)
);

// >>> verification/ier_host_acker.sv
`timescale 1ns/1ps

// ====================
// Host side of the interrupt handshake
module ier_host_acker (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       en,
    input wire logic [2:0] dly,
    input wire logic       irqReq,
    input wire logic [2:0] irqLevel,
    output logic           iackIn,
    output logic [2:0]     iackLevel
);
    logic [2:0] waitCnt_q;
    initial
    begin
        iackIn    = 1'b0;
        iackLevel = 3'h0;
        waitCnt_q = 3'h0;
    end
    // Idle level lines show the inverse so a stale match cannot pass
    always @(posedge clk)
    begin
        if (srst || !irqReq || !en || iackIn)
        begin
            waitCnt_q <= 3'h0;
            iackIn    <= 1'b0;
            iackLevel <= ~irqLevel;
        end
        else if (waitCnt_q == dly)
        begin
            iackIn    <= 1'b1;
            iackLevel <= irqLevel;
        end
        else
        begin
            waitCnt_q <= waitCnt_q + 3'h1;
        end
    end
endmodule : ier_host_acker

// >>> verification/test_isolated_input_event_recorder.sv
`timescale 1ns/1ps

module test_isolated_input_event_recorder;
    import ier_pkg::*;
    localparam int          TK = 200;
    localparam logic [15:0] ID = 16'h3C96; // Arbitrary board code
    logic        clk     = 1'b0;
    logic        srst    = 1'b1;
    logic [63:0] fieldIn = 64'h0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [15:0] paddr   = 16'h0000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [3:0]  pstrb   = 4'h0;
    logic [5:0]  addrMod = AM_A24_SUP;
    logic        ackEn   = 1'b0;
    logic [2:0]  ackDly  = 3'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, iackIn, irqReq, vectorValid, ledOn, boardOnline;
    logic [2:0]  iackLevel, irqLevel;
    logic [7:0]  vectorOut, rv;
    logic [5:0]  ch;
    logic [15:0] wo, bm, ca;
    logic [32:0] bq[$];
    logic [7:0]  vq[$];
    logic [5:0]  ams[4] = '{AM_A24_SUP, AM_A24_USR, AM_A16_SUP, AM_A16_USR};
    int          err_total = 0;
    int          n_tests   = 0;

    ier_event_recorder #(.TICK_CYCLES(TK), .WDOG_CYCLES(TK + 100), .BOARD_ID(ID))
    ier_event_recorder_i (
        .clk(clk), .srst(srst), .fieldIn(fieldIn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .addrMod(addrMod),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .iackIn(iackIn),
        .iackLevel(iackLevel), .irqReq(irqReq), .irqLevel(irqLevel), .vectorOut(vectorOut),
        .vectorValid(vectorValid), .ledOn(ledOn), .boardOnline(boardOnline));
    ier_host_acker ier_host_acker_i (
        .clk(clk), .srst(srst), .en(ackEn), .dly(ackDly), .irqReq(irqReq),
        .irqLevel(irqLevel), .iackIn(iackIn), .iackLevel(iackLevel));

    always #10 clk = ~clk;

    // ====================
    // Compare and bus tasks
    task automatic chk_bus(input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t bus exp %h got %h", $time, e, g);
        end
    endtask : chk_bus

    task automatic chk_vec(input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t vector exp %h got %h", $time, e, g);
        end
    endtask : chk_vec

    // Request is held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] d,
                       input logic [3:0] s, input logic [32:0] e);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {16'h0000, d};
        pstrb  <= s;
        bq.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        apb(1'b1, a, d, 4'h3, {1'b0, 32'h0000_0000});
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] d);
        apb(1'b0, a, 16'h0000, 4'h0, {1'b0, 16'h0000, d});
    endtask : rd

    task automatic bad(input logic w, input logic [15:0] a, input logic [3:0] s);
        apb(w, a, 16'hFFFF, s, {1'b1, 32'h0000_0000});
    endtask : bad

    task automatic endt(input string s);
        $display("test %s done", s);
    endtask : endt

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // ====================
    // Result watcher
    always @(posedge clk)
    begin
        if (psel && penable && pready)
            chk_bus(bq.size() > 0 ? bq.pop_front() : 'x, {pslverr, pwrite ? 32'h0 : prdata});
        if (vectorValid)
            chk_vec(vq.size() > 0 ? vq.pop_front() : 'x, vectorOut);
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        err_total++;
        print_verdict();
    end

    // ====================
    // Scenarios
    initial
    begin
        void'($urandom(49));
        ch     = 6'($urandom_range(63));
        rv     = 8'($urandom);
        ackDly = 3'($urandom_range(7));
        wo     = {12'h000, ch[5:4], 2'b00};
        bm     = 16'h0001 << ch[3:0];
        ca     = {8'h00, ch, 2'b00};
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd(OFF_ID, ID);
        rd(OFF_CSR, 16'h8200);
        for (int i = 0; i < 20000 && boardOnline !== 1'b1; i++)
            @(posedge clk);
        rd(OFF_CSR, 16'h8100);
        rd(OFF_STRES, 16'h0000);
        endt("selftest");
        foreach (ams[i])
        begin
            addrMod <= ams[i];
            rd(OFF_ID, ID);
        end
        addrMod <= 6'h3E;
        bad(1'b0, OFF_ID, 4'h0);
        addrMod <= AM_A24_SUP;
        bad(1'b0, 16'h0002, 4'h0);
        bad(1'b0, 16'h0030, 4'h0);
        bad(1'b1, OFF_MAXCNT, 4'h4);
        apb(1'b1, OFF_MAXCNT, 16'hABCD, 4'h1, {1'b0, 32'h0000_0000});
        rd(OFF_MAXCNT, 16'h00CD);
        endt("bus");
        ackEn <= 1'b1;
        wr(OFF_IVEC, {8'h03, rv});
        wr(OFF_CSR, 16'h8002);
        vq.push_back(rv);
        wr(OFF_TAG, 16'hFFFF);
        repeat (2 * TK + 80) @(posedge clk);
        rd(OFF_EVFLAG, 16'h0001);
        wr(OFF_EVFLAG, 16'h000F);
        rd(OFF_EVFLAG, 16'h0000);
        wr(OFF_IVEC, {8'h00, rv});
        wr(OFF_TAG, 16'hFFFF);
        repeat (2 * TK + 80) @(posedge clk);
        rd(OFF_EVFLAG, 16'h0001);
        wr(OFF_EVFLAG, 16'h000F);
        endt("interrupt");
        wr(OFF_MAXCNT, 16'h0002);
        wr(OFF_REQ, 16'h0000);
        wr(OFF_CFG + ca, 16'h1803);
        fieldIn[ch] <= 1'b1;
        repeat (2 * TK) @(posedge clk);
        rd(OFF_DEB + wo, 16'h0000);
        repeat (6 * TK) @(posedge clk);
        rd(OFF_DEB + wo, bm);
        rd(OFF_COSF + wo, bm);
        rd(OFF_EVCNT, 16'h0001);
        rd(OFF_PAC + ca, 16'h0001);
        fieldIn[ch] <= 1'b0;
        repeat (8 * TK) @(posedge clk);
        rd(OFF_DEB + wo, 16'h0000);
        rd(OFF_EVCNT, 16'h0002);
        rd(OFF_PAC + ca, 16'h0001);
        rd(OFF_EVFLAG, 16'h000C);
        wr(OFF_REQ, 16'h0000);
        rd(OFF_INDEX, 16'h0002);
        rd(OFF_EVCNT, 16'h0000);
        rd(OFF_BUF + 16'h0004, {8'h01, 2'b00, ch});
        rd(OFF_BUF + 16'h000C, {8'h00, 2'b00, ch});
        endt("events");
        wr(OFF_CSR, 16'h0000);
        rd(OFF_CSR, 16'h0100);
        endt("indicator");
        if (vq.size() != 0)
            err_total++;
        print_verdict();
    end
endmodule : test_isolated_input_event_recorder
